// ==== iord_pkg.sv ====
/*
 * package for the i/o register window decode block: offsets, field
 * positions, reset values, decode widths and the bus carrier struct.
 * assumes: included before iord_top.sv; no other dependencies.
 */
package iord_pkg;
    // ==========================================================
    // register window geometry
    localparam int WIN_BYTES = 256;
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 8;
    // ==========================================================
    // register offsets inside the window
    localparam logic [7:0] OFS_PA_IN = 8'h00;
    localparam logic [7:0] OFS_PB_IN = 8'h01;
    localparam logic [7:0] OFS_PA_MODE = 8'h02;
    localparam logic [7:0] OFS_PB_MODE = 8'h03;
    localparam logic [7:0] OFS_PA_OUT = 8'h04;
    localparam logic [7:0] OFS_PB_OUT = 8'h05;
    localparam logic [7:0] OFS_PA_DIR = 8'h06;
    localparam logic [7:0] OFS_PB_DIR = 8'h07;
    localparam logic [7:0] OFS_PA_DRV = 8'h08;
    localparam logic [7:0] OFS_PB_DRV = 8'h09;
    localparam logic [7:0] OFS_PA_ICELL = 8'h0a;
    localparam logic [7:0] OFS_PB_ICELL = 8'h0b;
    localparam logic [7:0] OFS_PA_OESTAT = 8'h0c;
    localparam logic [7:0] OFS_PB_OESTAT = 8'h0d;
    localparam logic [7:0] OFS_PC_IN = 8'h10;
    localparam logic [7:0] OFS_PD_IN = 8'h11;
    localparam logic [7:0] OFS_PC_OUT = 8'h12;
    localparam logic [7:0] OFS_PD_OUT = 8'h13;
    localparam logic [7:0] OFS_PC_DIR = 8'h14;
    localparam logic [7:0] OFS_PD_DIR = 8'h15;
    localparam logic [7:0] OFS_PC_DRV = 8'h16;
    localparam logic [7:0] OFS_PD_DRV = 8'h17;
    localparam logic [7:0] OFS_PC_ICELL = 8'h18;
    localparam logic [7:0] OFS_PC_OESTAT = 8'h1a;
    localparam logic [7:0] OFS_PD_OESTAT = 8'h1b;
    localparam logic [7:0] OFS_OCELL_AB = 8'h20;
    localparam logic [7:0] OFS_OCELL_BC = 8'h21;
    localparam logic [7:0] OFS_MASK_AB = 8'h22;
    localparam logic [7:0] OFS_MASK_BC = 8'h23;
    localparam logic [7:0] OFS_PWR_ZERO = 8'hb0;
    localparam logic [7:0] OFS_PWR_TWO = 8'hb4;
    localparam logic [7:0] OFS_PRI_PROT = 8'hc0;
    localparam logic [7:0] OFS_SEC_PROT = 8'hc2;
    localparam logic [7:0] OFS_TEST_EN = 8'hc7;
    localparam logic [7:0] OFS_PAGE = 8'he0;
    localparam logic [7:0] OFS_MEM_SPACE = 8'he2;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    // ==========================================================
    // memory-space assign fields: sram, secondary, primary, each
    // two bits wide (bit0 = program space, bit1 = data space)
    localparam int MSA_SRAM_LSB = 0;
    localparam int MSA_SEC_LSB = 2;
    localparam int MSA_PRI_LSB = 4;
    // ==========================================================
    // memory organisation
    localparam int PRI_SECTORS = 8;
    localparam int SEC_SECTORS = 4;
    localparam int PRI_SECTOR_BYTES = 32768;
    localparam int SEC_SECTOR_BYTES = 16384;
    // ==========================================================
    // controller kinds for latched address output
    typedef enum logic [1:0] {
        CTL_GENERIC_MUX = 2'b00,
        CTL_PAGE_MODE = 2'b01,
        CTL_WIDE_8BIT = 2'b10,
        CTL_NON_MUX = 2'b11
    } iord_ctl_kind_t;
    // ==========================================================
    // register bus request carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } iord_bus_req_t;
    // decode array select outputs
    typedef struct packed {
        logic [PRI_SECTORS-1:0] pri;
        logic [SEC_SECTORS-1:0] sec;
        logic sram;
        logic win;
    } iord_sel_t;
endpackage

// ==== iord_top.sv ====
/*
 * register window decode for the i/o, macrocell, power and mapping
 * registers of a flash peripheral, plus the memory select logic.
 * assumes: a synchronous 8-bit controller bus sampled on CORE_CLK_I,
 * one byte per cycle; pin inputs arrive asynchronously.
 */
`timescale 1ns/100ps
module iord_top
    import iord_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    input wire iord_bus_req_t BUS_REQ_I,
    input wire logic [ADDR_W-1:0] WIN_BASE_I,
    input wire iord_ctl_kind_t CTL_KIND_I,
    input wire logic [PORT_W-1:0] PA_PIN_I,
    input wire logic [PORT_W-1:0] PB_PIN_I,
    input wire logic [PORT_W-1:0] PC_PIN_I,
    input wire logic [PORT_W-1:0] PD_PIN_I,
    input wire logic [7:0] PRI_PROT_I,
    input wire logic [7:0] SEC_PROT_I,
    input wire logic [PRI_SECTORS-1:0] PRI_SEL_I,
    input wire logic [SEC_SECTORS-1:0] SEC_SEL_I,
    input wire logic SRAM_SEL_I,
    output logic [7:0] RDATA_O,
    output logic [PORT_W-1:0] PA_OUT_O,
    output logic [PORT_W-1:0] PA_OE_O,
    output logic [PORT_W-1:0] PB_OUT_O,
    output logic [PORT_W-1:0] PB_OE_O,
    output logic [PORT_W-1:0] PC_OUT_O,
    output logic [PORT_W-1:0] PC_OE_O,
    output logic [PORT_W-1:0] PD_OUT_O,
    output logic [PORT_W-1:0] PD_OE_O,
    output logic [PORT_W-1:0] PA_ODRAIN_O,
    output logic [PORT_W-1:0] PB_ODRAIN_O,
    output logic [PORT_W-1:0] PC_ODRAIN_O,
    output logic [PORT_W-1:0] PD_ODRAIN_O,
    output logic [7:0] OCELL_AB_O,
    output logic [7:0] OCELL_BC_O,
    output logic [7:0] PWR_ZERO_O,
    output logic [7:0] PWR_TWO_O,
    output logic [7:0] TEST_EN_O,
    output logic [PAGE_W-1:0] PAGE_O,
    output logic [7:0] MEM_SPACE_O,
    output iord_sel_t SEL_O
);

    // elaboration check: the register map is built on eight-bit ports
    if (PORT_W != 8) begin : g_bad_port_w
        $error("iord_top: ports are eight bits wide");
    end

    // ==========================================================
    // pin input synchronisers, three stages, change when 2 and 3 agree
    logic [4*PORT_W-1:0] pin_s1_q;
    logic [4*PORT_W-1:0] pin_s2_q;
    logic [4*PORT_W-1:0] pin_s3_q;
    logic [4*PORT_W-1:0] pin_q;
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            pin_s1_q <= {PD_PIN_I, PC_PIN_I, PB_PIN_I, PA_PIN_I};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // per-bit filtered level
    genvar gi;
    generate
        for (gi = 0; gi < 4*PORT_W; gi++) begin : g_pin
            always_ff @(posedge CORE_CLK_I) begin
                if (!RESETN_I) begin
                    pin_q[gi] <= 1'b0;
                end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                    pin_q[gi] <= pin_s3_q[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // window decode
    logic [ADDR_W-1:0] rel;
    logic in_win;
    logic [7:0] ofs;
    logic wr_en;
    assign rel = BUS_REQ_I.addr - WIN_BASE_I;
    assign in_win = (rel < ADDR_W'(WIN_BYTES));
    assign ofs = rel[7:0];
    assign wr_en = BUS_REQ_I.wr && in_win;

    // ==========================================================
    // writable registers
    logic [7:0] pa_mode_q, pb_mode_q;
    logic [7:0] pa_out_q, pb_out_q, pc_out_q, pd_out_q;
    logic [7:0] pa_dir_q, pb_dir_q, pc_dir_q, pd_dir_q;
    logic [7:0] pa_drv_q, pb_drv_q, pc_drv_q, pd_drv_q;
    logic [7:0] mask_ab_q, mask_bc_q;
    logic [7:0] pwr_zero_q, pwr_two_q, test_en_q, page_q, mem_space_q;
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            pa_mode_q <= RST_ZERO;
            pb_mode_q <= RST_ZERO;
            pa_out_q <= RST_ZERO;
            pb_out_q <= RST_ZERO;
            pc_out_q <= RST_ZERO;
            pd_out_q <= RST_ZERO;
            pa_dir_q <= RST_ZERO;
            pb_dir_q <= RST_ZERO;
            pc_dir_q <= RST_ZERO;
            pd_dir_q <= RST_ZERO;
            pa_drv_q <= RST_ZERO;
            pb_drv_q <= RST_ZERO;
            pc_drv_q <= RST_ZERO;
            pd_drv_q <= RST_ZERO;
            mask_ab_q <= RST_ZERO;
            mask_bc_q <= RST_ZERO;
            pwr_zero_q <= RST_ZERO;
            pwr_two_q <= RST_ZERO;
            test_en_q <= RST_ZERO;
            page_q <= RST_ZERO;
            mem_space_q <= RST_ZERO;
        end else if (wr_en) begin
            // unlisted offsets fall through and change nothing
            if (ofs == OFS_PA_MODE) pa_mode_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PB_MODE) pb_mode_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PA_OUT) pa_out_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PB_OUT) pb_out_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PC_OUT) pc_out_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PD_OUT) pd_out_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PA_DIR) pa_dir_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PB_DIR) pb_dir_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PC_DIR) pc_dir_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PD_DIR) pd_dir_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PA_DRV) pa_drv_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PB_DRV) pb_drv_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PC_DRV) pc_drv_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PD_DRV) pd_drv_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_MASK_AB) mask_ab_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_MASK_BC) mask_bc_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PWR_ZERO) pwr_zero_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PWR_TWO) pwr_two_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_TEST_EN) test_en_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_PAGE) page_q <= BUS_REQ_I.wdata;
            else if (ofs == OFS_MEM_SPACE) mem_space_q <= BUS_REQ_I.wdata;
        end
    end

    // ==========================================================
    // output cells, masked bits keep their value
    logic [7:0] ocell_ab_q, ocell_bc_q;
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            ocell_ab_q <= RST_ZERO;
            ocell_bc_q <= RST_ZERO;
        end else if (wr_en && ofs == OFS_OCELL_AB) begin
            ocell_ab_q <= (ocell_ab_q & mask_ab_q) | (BUS_REQ_I.wdata & ~mask_ab_q);
        end else if (wr_en && ofs == OFS_OCELL_BC) begin
            ocell_bc_q <= (ocell_bc_q & mask_bc_q) | (BUS_REQ_I.wdata & ~mask_bc_q);
        end
    end

    // ==========================================================
    // latched address per port byte, by controller kind
    logic [7:0] pa_addr_d, pb_addr_d;
    always_comb begin
        pa_addr_d = 8'h00;
        pb_addr_d = 8'h00;
        case (CTL_KIND_I)
            CTL_GENERIC_MUX: begin
                pa_addr_d = BUS_REQ_I.addr[7:0];
                pb_addr_d = BUS_REQ_I.addr[7:0];
            end
            CTL_PAGE_MODE: begin
                pb_addr_d = BUS_REQ_I.addr[15:8];
            end
            CTL_WIDE_8BIT: begin
                pa_addr_d = {BUS_REQ_I.addr[7:4], 4'h0};
                pb_addr_d = {4'h0, BUS_REQ_I.addr[11:8]};
            end
            default: begin
                pb_addr_d = BUS_REQ_I.addr[7:0];
            end
        endcase
    end

    // port pin drive: mode bit selects latched address over data out
    logic [7:0] pa_drive_d, pb_drive_d;
    logic [7:0] pa_oe_d, pb_oe_d;
    assign pa_drive_d = (pa_mode_q & pa_addr_d) | (~pa_mode_q & pa_out_q);
    assign pb_drive_d = (pb_mode_q & pb_addr_d) | (~pb_mode_q & pb_out_q);
    assign pa_oe_d = pa_dir_q | pa_mode_q;
    assign pb_oe_d = pb_dir_q | pb_mode_q;

    // registered pin drive; open-drain pins release on a one
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            PA_OUT_O <= '0;
            PB_OUT_O <= '0;
            PC_OUT_O <= '0;
            PD_OUT_O <= '0;
            PA_OE_O <= '0;
            PB_OE_O <= '0;
            PC_OE_O <= '0;
            PD_OE_O <= '0;
            PA_ODRAIN_O <= '0;
            PB_ODRAIN_O <= '0;
            PC_ODRAIN_O <= '0;
            PD_ODRAIN_O <= '0;
        end else begin
            PA_OUT_O <= pa_drive_d;
            PB_OUT_O <= pb_drive_d;
            PC_OUT_O <= pc_out_q;
            PD_OUT_O <= pd_out_q;
            PA_OE_O <= pa_oe_d & ~(pa_drv_q & pa_drive_d);
            PB_OE_O <= pb_oe_d & ~(pb_drv_q & pb_drive_d);
            PC_OE_O <= pc_dir_q & ~(pc_drv_q & pc_out_q);
            PD_OE_O <= pd_dir_q & ~(pd_drv_q & pd_out_q);
            PA_ODRAIN_O <= pa_drv_q;
            PB_ODRAIN_O <= pb_drv_q;
            PC_ODRAIN_O <= pc_drv_q;
            PD_ODRAIN_O <= pd_drv_q;
        end
    end

    // ==========================================================
    // read mux, answer registered on the edge that takes the read
    logic [7:0] rdata_d;
    always_comb begin
        rdata_d = 8'h00;
        if (!(BUS_REQ_I.rd && in_win)) rdata_d = 8'h00;
        else if (ofs == OFS_PA_IN) rdata_d = pin_q[7:0];
        else if (ofs == OFS_PB_IN) rdata_d = pin_q[15:8];
        else if (ofs == OFS_PC_IN) rdata_d = pin_q[23:16];
        else if (ofs == OFS_PD_IN) rdata_d = pin_q[31:24];
        else if (ofs == OFS_PA_MODE) rdata_d = pa_mode_q;
        else if (ofs == OFS_PB_MODE) rdata_d = pb_mode_q;
        else if (ofs == OFS_PA_OUT) rdata_d = pa_out_q;
        else if (ofs == OFS_PB_OUT) rdata_d = pb_out_q;
        else if (ofs == OFS_PC_OUT) rdata_d = pc_out_q;
        else if (ofs == OFS_PD_OUT) rdata_d = pd_out_q;
        else if (ofs == OFS_PA_DIR) rdata_d = pa_dir_q;
        else if (ofs == OFS_PB_DIR) rdata_d = pb_dir_q;
        else if (ofs == OFS_PC_DIR) rdata_d = pc_dir_q;
        else if (ofs == OFS_PD_DIR) rdata_d = pd_dir_q;
        else if (ofs == OFS_PA_DRV) rdata_d = pa_drv_q;
        else if (ofs == OFS_PB_DRV) rdata_d = pb_drv_q;
        else if (ofs == OFS_PC_DRV) rdata_d = pc_drv_q;
        else if (ofs == OFS_PD_DRV) rdata_d = pd_drv_q;
        else if (ofs == OFS_PA_ICELL) rdata_d = pin_q[7:0];
        else if (ofs == OFS_PB_ICELL) rdata_d = pin_q[15:8];
        else if (ofs == OFS_PC_ICELL) rdata_d = pin_q[23:16];
        else if (ofs == OFS_PA_OESTAT) rdata_d = PA_OE_O;
        else if (ofs == OFS_PB_OESTAT) rdata_d = PB_OE_O;
        else if (ofs == OFS_PC_OESTAT) rdata_d = PC_OE_O;
        else if (ofs == OFS_PD_OESTAT) rdata_d = PD_OE_O;
        else if (ofs == OFS_OCELL_AB) rdata_d = ocell_ab_q;
        else if (ofs == OFS_OCELL_BC) rdata_d = ocell_bc_q;
        else if (ofs == OFS_MASK_AB) rdata_d = mask_ab_q;
        else if (ofs == OFS_MASK_BC) rdata_d = mask_bc_q;
        else if (ofs == OFS_PWR_ZERO) rdata_d = pwr_zero_q;
        else if (ofs == OFS_PWR_TWO) rdata_d = pwr_two_q;
        else if (ofs == OFS_PRI_PROT) rdata_d = PRI_PROT_I;
        else if (ofs == OFS_SEC_PROT) rdata_d = SEC_PROT_I;
        else if (ofs == OFS_TEST_EN) rdata_d = test_en_q;
        else if (ofs == OFS_PAGE) rdata_d = page_q;
        else if (ofs == OFS_MEM_SPACE) rdata_d = mem_space_q;
    end

    // registered read data and register-driven outputs
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            RDATA_O <= 8'h00;
            OCELL_AB_O <= 8'h00;
            OCELL_BC_O <= 8'h00;
            PWR_ZERO_O <= 8'h00;
            PWR_TWO_O <= 8'h00;
            TEST_EN_O <= 8'h00;
            PAGE_O <= '0;
            MEM_SPACE_O <= 8'h00;
        end else begin
            RDATA_O <= rdata_d;
            OCELL_AB_O <= ocell_ab_q;
            OCELL_BC_O <= ocell_bc_q;
            PWR_ZERO_O <= pwr_zero_q;
            PWR_TWO_O <= pwr_two_q;
            TEST_EN_O <= test_en_q;
            PAGE_O <= page_q;
            MEM_SPACE_O <= mem_space_q;
        end
    end

    // ==========================================================
    // memory selects passed from the user decode array, registered
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            SEL_O <= '0;
        end else begin
            SEL_O.pri <= PRI_SEL_I;
            SEL_O.sec <= SEC_SEL_I;
            SEL_O.sram <= SRAM_SEL_I;
            SEL_O.win <= in_win && (BUS_REQ_I.rd || BUS_REQ_I.wr);
        end
    end

    // ==========================================================
    // assertions
    a_unmapped_reads_zero: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (BUS_REQ_I.rd && in_win && ofs == 8'h30) |=> RDATA_O == 8'h00)
        else $error("unassigned offset read returned nonzero");
    a_outside_window_zero: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (BUS_REQ_I.rd && !in_win) |=> RDATA_O == 8'h00)
        else $error("read outside window returned data");
    a_page_write_lands: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (wr_en && ofs == OFS_PAGE) |=> ##1 PAGE_O == $past(BUS_REQ_I.wdata, 2))
        else $error("page write not visible");
    a_masked_cell_holds: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (wr_en && ofs == OFS_OCELL_AB) |=> ((ocell_ab_q ^ $past(ocell_ab_q)) & mask_ab_q) == 8'h00)
        else $error("masked output cell changed");
    a_bc_cell_load: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (wr_en && ofs == OFS_OCELL_BC && mask_bc_q == 8'h00) |=> ocell_bc_q == $past(BUS_REQ_I.wdata))
        else $error("group bc cell load failed");
    a_pri_prot_read: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (BUS_REQ_I.rd && in_win && ofs == OFS_PRI_PROT) |=> RDATA_O == $past(PRI_PROT_I))
        else $error("primary protection read wrong");
    a_sec_prot_read: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (BUS_REQ_I.rd && in_win && ofs == OFS_SEC_PROT) |=> RDATA_O == $past(SEC_PROT_I))
        else $error("secondary protection read wrong");
    a_pc_output_drive: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (wr_en && ofs == OFS_PC_OUT) |=> ##1 PC_OUT_O == $past(BUS_REQ_I.wdata, 2))
        else $error("port c output not driven");
    a_power_write: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (wr_en && ofs == OFS_PWR_TWO) |=> ##1 PWR_TWO_O == $past(BUS_REQ_I.wdata, 2))
        else $error("power register write lost");
    // latched address on the pins and open-drain release
    a_generic_addr_out: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (CTL_KIND_I == CTL_GENERIC_MUX && pa_mode_q == 8'hff) |=> PA_OUT_O == $past(BUS_REQ_I.addr[7:0]))
        else $error("generic latched address wrong");
    a_page_addr_out: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (CTL_KIND_I == CTL_PAGE_MODE && pb_mode_q == 8'hff) |=> PB_OUT_O == $past(BUS_REQ_I.addr[15:8]))
        else $error("page-mode latched address wrong");
    a_open_drain_release: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        (pc_drv_q[0] && pc_out_q[0]) |=> !PC_OE_O[0])
        else $error("open-drain pin driven high");
endmodule

// ==== iord_mcu_model.sv ====
/*
 * controller-side bus model for the register window decode block.
 * assumes: one byte per ordinary bus cycle, strobes changed at the
 * falling edge, read data registered on the taking edge and sampled at the next falling edge.
 */
`timescale 1ns/100ps
module iord_mcu_model
    import iord_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output iord_bus_req_t req_o
);
    // ==========================================================
    // bus cycle
    initial req_o = '0;
    // one strobe per access, rd and wr never together
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge clk_i);
        req_o = '{w, !w, a, d};
        @(posedge clk_i);
        // registered answer stands only until the next rising edge
        @(negedge clk_i);
        q = rdata_i;
        // released bus shows no stale address or data
        req_o = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

// ==== tb.sv ====
/*
 * self-checking testbench for the register window decode block.
 * assumes: iord_pkg, iord_top and iord_mcu_model are compiled first.
 */
`timescale 1ns/100ps
module tb;
    import iord_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic [15:0] base = 16'h4000;
    logic [7:0] pin_a = 8'h11, pin_b = 8'h22, pin_c = 8'h44, pin_d = 8'h88;
    logic [7:0] rdata, q;
    logic [7:0] pa_out, pa_oe, oc_ab, page;
    logic [7:0] pb_out, pd_out, pc_odrain, oc_bc, pwr0, test_en, mem_space;
    iord_ctl_kind_t ctl = CTL_GENERIC_MUX;
    iord_sel_t sel;
    iord_bus_req_t req;
    int n_mismatch = 0;
    int check_count = 0;
    logic [7:0] rw_ofs [20] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
        8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h22, 8'hb0, 8'hb4, 8'hc7, 8'he0, 8'he2};
    // ==========================================================
    // clock, design and controller model
    initial forever #20 clk = ~clk;
    iord_top DUT (.CORE_CLK_I(clk), .RESETN_I(rst_n), .BUS_REQ_I(req), .WIN_BASE_I(base),
        .CTL_KIND_I(ctl), .PA_PIN_I(pin_a), .PB_PIN_I(pin_b), .PC_PIN_I(pin_c),
        .PD_PIN_I(pin_d), .PRI_PROT_I(8'h5c), .SEC_PROT_I(8'h83), .PRI_SEL_I(8'h6a),
        .SEC_SEL_I(4'h9), .SRAM_SEL_I(1'b1), .RDATA_O(rdata), .PA_OUT_O(pa_out),
        .PA_OE_O(pa_oe), .PB_OUT_O(pb_out), .PB_OE_O(), .PC_OUT_O(), .PC_OE_O(),
        .PD_OUT_O(pd_out), .PD_OE_O(), .PA_ODRAIN_O(), .PB_ODRAIN_O(),
        .PC_ODRAIN_O(pc_odrain), .PD_ODRAIN_O(), .OCELL_AB_O(oc_ab), .OCELL_BC_O(oc_bc),
        .PWR_ZERO_O(pwr0), .PWR_TWO_O(), .TEST_EN_O(test_en), .PAGE_O(page),
        .MEM_SPACE_O(mem_space), .SEL_O(sel));
    iord_mcu_model mcu (.clk_i(clk), .rdata_i(rdata), .req_o(req));
    // ==========================================================
    // access and compare tasks
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        mcu.xfer(1'b1, base + {8'h00, ofs}, d, q);
    endtask
    task automatic rd_at(input logic [15:0] a, input logic [7:0] exp);
        mcu.xfer(1'b0, a, 8'h00, q);
        chk("read data", q, exp);
    endtask
    task automatic stop_test;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========================================================
    // watchdog
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
    // ==========================================================
    // test sequence
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1;
        rd_at(base + 16'h00e0, 8'h00);
        foreach (rw_ofs[i]) wr(rw_ofs[i], rw_ofs[i] ^ 8'ha5);
        foreach (rw_ofs[i]) rd_at(base + {8'h00, rw_ofs[i]}, rw_ofs[i] ^ 8'ha5);
        chk("page out", page, 8'h45);
        chk("power zero out", pwr0, 8'h15);
        chk("test enable out", test_en, 8'h62);
        chk("memory space out", mem_space, 8'h47);
        chk("port c drive type", pc_odrain, 8'hb3);
        chk("port d drive", pd_out, 8'hb6);
        chk("primary selects", sel.pri, 8'h6a);
        chk("secondary selects", {4'h0, sel.sec}, 8'h09);
        chk("sram select", {7'h00, sel.sram}, 8'h01);
        // clear mode and drive so that direction alone sets the enables
        wr(8'h02, 8'h00);
        wr(8'h08, 8'h00);
        wr(8'h06, 8'h3c);
        wr(8'h04, 8'h96);
        rd_at(base + 16'h000c, 8'h3c);
        chk("port a enable", pa_oe, 8'h3c);
        chk("port a drive", pa_out, 8'h96);
        // pin inputs and input cells
        rd_at(base + 16'h0000, 8'h11);
        rd_at(base + 16'h0001, 8'h22);
        rd_at(base + 16'h0010, 8'h44);
        rd_at(base + 16'h0011, 8'h88);
        rd_at(base + 16'h000a, 8'h11);
        // a pin change shows once the synchroniser has settled
        pin_c = 8'h3c;
        repeat (4) @(negedge clk);
        rd_at(base + 16'h0010, 8'h3c);
        // read-only status ignores writes
        wr(8'hc0, 8'hff);
        wr(8'hc2, 8'h00);
        rd_at(base + 16'h00c0, 8'h5c);
        rd_at(base + 16'h00c2, 8'h83);
        // masked output cells keep their value
        wr(8'h22, 8'hf0);
        wr(8'h20, 8'hff);
        rd_at(base + 16'h0020, 8'h0f);
        chk("cells ab", oc_ab, 8'h0f);
        wr(8'h23, 8'h00);
        wr(8'h21, 8'h3c);
        rd_at(base + 16'h0021, 8'h3c);
        chk("cells bc", oc_bc, 8'h3c);
        // unassigned offset and accesses outside the window
        wr(8'h30, 8'hff);
        rd_at(base + 16'h0030, 8'h00);
        mcu.xfer(1'b1, base - 16'h0001, 8'h77, q);
        rd_at(base - 16'h0001, 8'h00);
        rd_at(base + 16'h0100, 8'h00);
        chk("window select off", {7'h00, sel.win}, 8'h00);
        // moving the base moves the whole map
        base = 16'h9000;
        rd_at(16'h90e0, 8'h45);
        chk("window select on", {7'h00, sel.win}, 8'h01);
        rd_at(16'h40e0, 8'h00);
        // latched address on the port pins, for the generic, page-mode and wide controller kinds
        wr(8'h02, 8'hff);
        wr(8'h03, 8'hff);
        mcu.xfer(1'b0, 16'h5ab7, 8'h00, q);
        chk("port a address", pa_out, 8'hb7);
        chk("port b address", pb_out, 8'hb7);
        ctl = CTL_PAGE_MODE;
        mcu.xfer(1'b0, 16'h5ab7, 8'h00, q);
        chk("port b page address", pb_out, 8'h5a);
        ctl = CTL_WIDE_8BIT;
        mcu.xfer(1'b0, 16'h5ab7, 8'h00, q);
        chk("port a wide address", pa_out, 8'hb0);
        chk("port b wide address", pb_out, 8'h0a);
        // a second reset clears the registers again
        rst_n = 0;
        repeat (2) @(negedge clk);
        rst_n = 1;
        rd_at(16'h90e0, 8'h00);
        chk("page out after reset", page, 8'h00);
        stop_test();
    end
endmodule
